// ==== host_interface_autodetect.sv ====
// Overview of operation
// - every reset clears the detected interface and starts a fresh detection.
// - the interface type comes from strap levels sampled once reset is over and, for the dedicated bus strobe, from DED_COMMON_STROBE.
// - bus-select and address-mode both 0 give UART, 0 and 1 give SPI, bus-select 1 gives I2C with address-mode kept.
// - serial modes need A5..A2 at 0 and both strobes high, with A1/A0 choosing UART, SPI or I2C.
// - A5..A3 at 0 with A2, A1 at 1 give multiplexed mode, A0 picks separate or common strobe, latch pin high gives dedicated bus.
// - shared pins take SPI, UART, I2C or parallel bus roles according to the detected type.
`include "host_if_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module host_interface_autodetect
    import host_if_pkg::*;
#(
    parameter bit DED_COMMON_STROBE = 1'b0
)
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // strap and shared pins
    input  wire logic       latch_enable_pin,
    output logic            latch_enable_out,
    output logic            latch_enable_oe,
    input  wire logic [5:0] addr_pin,
    input  wire logic       read_strobe_n,
    input  wire logic       write_strobe_n,
    input  wire logic       chip_select_n,
    input  wire logic [7:0] data_pin_in,
    output logic      [7:0] data_pin_out,
    output logic      [7:0] data_pin_oe,
    // from the serial and parallel cores
    input  wire logic       uart_tx_data,
    input  wire logic       uart_mux_out,
    input  wire logic       uart_transfer_request,
    input  wire logic       spi_miso,
    input  wire logic       i2c_sda_low,
    input  wire logic [7:0] par_data_out,
    input  wire logic       par_data_oe,
    // detection result and core-side pin roles
    output mode_t           host_mode,
    output logic            mode_valid,
    output logic            uart_rx,
    output spi_bus_t        spi_bus,
    output i2c_bus_t        i2c_bus,
    output par_bus_t        par_bus
);

    function automatic mode_t decode_mode(input strap_t s, input bit ded_common);
        logic serial_pat;
        logic mux_pat;
        serial_pat = (s.addr[5:2] == 4'h0) && s.rd_n && s.wr_n;
        mux_pat    = (s.addr[5:3] == 3'h0) && s.addr[2] && s.addr[1];
        if (serial_pat && s.addr[`HIF_A_BUS_SEL])
            decode_mode = MODE_I2C;
        else if (serial_pat && s.addr[`HIF_A_ADDR_MODE])
            decode_mode = MODE_SPI;
        else if (serial_pat)
            decode_mode = MODE_UART;
        else if (mux_pat && s.addr[`HIF_A_ADDR_MODE])
            decode_mode = MODE_SEP_MUX;
        else if (mux_pat)
            decode_mode = MODE_COM_MUX;
        else if (s.latch_en)
            decode_mode = ded_common ? MODE_COM_DED : MODE_SEP_DED;
        else
            decode_mode = MODE_NONE;
    endfunction : decode_mode

    strap_t     strap;
    hif_state_t state_r;
    hif_state_t state_nxt;
    logic [2:0] settle_r;
    logic [2:0] settle_nxt;
    mode_t      mode_nxt;
    logic [7:0] dout_nxt;
    logic [7:0] doe_nxt;
    logic       lat_oe_nxt;

    pin_sync #(.WIDTH($bits(strap_t))) u_sync
    (
        .core_clk  (core_clk),
        .rst       (rst),
        .pins      ({latch_enable_pin, addr_pin, read_strobe_n, write_strobe_n, chip_select_n, data_pin_in}),
        .pins_sync (strap)
    );

    // detection happens once; the strap pins are ignored afterwards
    wire   capture     = (state_r == ST_SETTLE) && (settle_r == 3'h0);
    wire   settle_tick = (state_r == ST_SETTLE) && (settle_r != 3'h0);
    wire   mode_t det  = decode_mode(strap, DED_COMMON_STROBE);
    assign state_nxt   = capture ? ST_RUN : state_r;
    assign settle_nxt  = settle_tick ? settle_r - 3'h1 : settle_r;
    assign mode_nxt    = capture ? det : host_mode;

    wire is_uart   = mode_valid && (host_mode == MODE_UART);
    wire is_spi    = mode_valid && (host_mode == MODE_SPI);
    wire is_i2c    = mode_valid && (host_mode == MODE_I2C);
    wire is_par    = mode_valid && host_mode[2];
    // miso only drives while the host selects us, so a shared bus is not fought
    wire spi_drive = is_spi && !strap.latch_en;

    assign dout_nxt = is_uart ? {uart_tx_data, uart_mux_out, uart_transfer_request, 5'h00}
                    : is_spi  ? {spi_miso, 7'h00}
                    : is_par  ? par_data_out
                    : `HIF_DATA_OUT_RESET;
    assign doe_nxt  = is_uart   ? `HIF_UART_OE
                    : spi_drive ? `HIF_SPI_OE
                    : (is_par && par_data_oe) ? 8'hff
                    : `HIF_DATA_OE_RESET;
    // open drain: only ever pull sda low
    assign lat_oe_nxt = is_i2c && i2c_sda_low;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state_r   <= ST_SETTLE;
            settle_r  <= 3'(`HIF_SETTLE_CNT);
            host_mode <= MODE_NONE;
            mode_valid <= 1'b0;
        end
        else
        begin
            state_r    <= state_nxt;
            settle_r   <= settle_nxt;
            host_mode  <= mode_nxt;
            mode_valid <= (state_nxt == ST_RUN);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            data_pin_out     <= `HIF_DATA_OUT_RESET;
            data_pin_oe      <= `HIF_DATA_OE_RESET;
            latch_enable_out <= 1'b0;
            latch_enable_oe  <= 1'b0;
            uart_rx          <= 1'b1;
            spi_bus          <= '{nss: 1'b1, mosi: 1'b0, sck: 1'b0, cs_n: 1'b1};
            i2c_bus          <= '{scl: 1'b1, sda_in: 1'b1, address_mode_pin: 1'b0, slave_addr: 7'h00};
            par_bus          <= '0;
        end
        else
        begin
            data_pin_out     <= dout_nxt;
            data_pin_oe      <= doe_nxt;
            latch_enable_out <= 1'b0;
            latch_enable_oe  <= lat_oe_nxt;
            uart_rx          <= is_uart ? strap.latch_en : 1'b1;
            spi_bus.nss      <= is_spi ? strap.latch_en : 1'b1;
            spi_bus.mosi     <= is_spi && strap.data[`HIF_D_MUX_MOSI];
            spi_bus.sck      <= is_spi && strap.data[`HIF_D_REQ_SCK];
            spi_bus.cs_n     <= strap.cs_n;
            i2c_bus.scl      <= is_i2c ? strap.data[`HIF_D_TX_MISO_SCL] : 1'b1;
            i2c_bus.sda_in   <= is_i2c ? strap.latch_en : 1'b1;
            i2c_bus.address_mode_pin <= is_i2c && strap.addr[`HIF_A_ADDR_MODE];
            // adr_0 sits on d6 down to adr_6 on d0
            i2c_bus.slave_addr <= is_i2c ? {strap.data[0], strap.data[1], strap.data[2], strap.data[3],
                                            strap.data[4], strap.data[5], strap.data[6]} : 7'h00;
            par_bus          <= is_par ? par_bus_t'{ale_or_strobe: strap.latch_en, addr: strap.addr,
                                           read_strobe_n: strap.rd_n, write_strobe_n: strap.wr_n,
                                           chip_select_n: strap.cs_n, data: strap.data} : '0;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    localparam int SETTLE_MAX = 8;

    sequence serial_strap_s;
        capture && (strap.addr[5:2] == 4'h0) && strap.rd_n && strap.wr_n;
    endsequence

    sequence mux_strap_s;
        capture && (strap.addr[5:3] == 3'h0) && strap.addr[2] && strap.addr[1];
    endsequence

    reset_clears_a: assert property (disable iff (1'b0) rst |=> !mode_valid && host_mode == MODE_NONE)
        else $error("reset did not clear detection");

    detect_after_reset_a: assert property ($fell(rst) |-> ##[1:SETTLE_MAX] mode_valid)
        else $error("no detection after reset release");

    uart_decode_a: assert property (serial_strap_s ##0 (strap.addr[1:0] == 2'h0) |=> host_mode == MODE_UART)
        else $error("uart strap not decoded");

    spi_decode_a: assert property (serial_strap_s ##0 (strap.addr[1:0] == 2'h1) |=> host_mode == MODE_SPI)
        else $error("spi strap not decoded");

    i2c_decode_a: assert property (serial_strap_s ##0 strap.addr[1] |=> host_mode == MODE_I2C
                                   ##1 i2c_bus.address_mode_pin == $past(strap.addr[0]))
        else $error("i2c strap not decoded");

    mux_decode_a: assert property (mux_strap_s |=> host_mode == ($past(strap.addr[0]) ? MODE_SEP_MUX : MODE_COM_MUX))
        else $error("multiplexed strap not decoded");

    uart_pins_a: assert property (is_uart |=> data_pin_oe == 8'he0 && data_pin_out[7] == $past(uart_tx_data))
        else $error("uart pin roles wrong");

    spi_miso_a: assert property (spi_drive |=> data_pin_oe[7] && data_pin_out[7] == $past(spi_miso))
        else $error("spi miso not driven");

    mode_hold_a: assert property (mode_valid |=> $stable(host_mode) && mode_valid)
        else $error("detected mode changed");

    spi_roles_a: assert property (is_spi |=> spi_bus.nss == $past(strap.latch_en)
                                  && spi_bus.sck == $past(strap.data[`HIF_D_REQ_SCK]))
        else $error("spi pin roles wrong");

    spi_idle_a: assert property (!is_spi |=> spi_bus.nss && !spi_bus.mosi && !spi_bus.sck)
        else $error("spi lines active outside spi mode");

    sda_pull_a: assert property (is_i2c && i2c_sda_low |=> latch_enable_oe && !latch_enable_out)
        else $error("sda not pulled low");

endmodule : host_interface_autodetect

`default_nettype wire

// ==== host_if_consts.svh ====
`ifndef HOST_IF_CONSTS_SVH
`define HOST_IF_CONSTS_SVH

// clock and strap settle timing
`define HIF_CLK_PERIOD_NS     8
`define HIF_STRAP_SETTLE_NS   24
`define HIF_SETTLE_CYC        ((`HIF_STRAP_SETTLE_NS + `HIF_CLK_PERIOD_NS - 1) / `HIF_CLK_PERIOD_NS)
`define HIF_SYNC_DEPTH        2
`define HIF_SETTLE_CNT        (`HIF_SETTLE_CYC + `HIF_SYNC_DEPTH)

// address strap field positions
`define HIF_A_BUS_SEL         1
`define HIF_A_ADDR_MODE       0

// data pin roles in serial modes
`define HIF_D_TX_MISO_SCL     7
`define HIF_D_MUX_MOSI        6
`define HIF_D_REQ_SCK         5

// pin drive reset values and serial mode output enables
`define HIF_DATA_OE_RESET     8'h00
`define HIF_DATA_OUT_RESET    8'h00
`define HIF_UART_OE           8'he0
`define HIF_SPI_OE            8'h80

`endif

// ==== host_if_pkg.sv ====
package host_if_pkg;

    typedef enum logic [2:0]
    {
        MODE_NONE    = 3'h0,
        MODE_UART    = 3'h1,
        MODE_SPI     = 3'h2,
        MODE_I2C     = 3'h3,
        MODE_SEP_MUX = 3'h4,
        MODE_COM_MUX = 3'h5,
        MODE_SEP_DED = 3'h6,
        MODE_COM_DED = 3'h7
    } mode_t;

    typedef enum logic
    {
        ST_SETTLE = 1'h0,
        ST_RUN    = 1'h1
    } hif_state_t;

    typedef struct packed
    {
        logic       latch_en;
        logic [5:0] addr;
        logic       rd_n;
        logic       wr_n;
        logic       cs_n;
        logic [7:0] data;
    } strap_t;

    typedef struct packed
    {
        logic nss;
        logic mosi;
        logic sck;
        logic cs_n;
    } spi_bus_t;

    typedef struct packed
    {
        logic       scl;
        logic       sda_in;
        logic       address_mode_pin;
        logic [6:0] slave_addr;
    } i2c_bus_t;

    typedef struct packed
    {
        logic       ale_or_strobe;
        logic [5:0] addr;
        logic       read_strobe_n;
        logic       write_strobe_n;
        logic       chip_select_n;
        logic [7:0] data;
    } par_bus_t;

endpackage : host_if_pkg

// ==== pin_sync.sv ====
`timescale 1ns/100ps
`default_nettype none

module pin_sync
#(
    parameter int WIDTH = 18
)
(
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // raw pins and synchronised copy
    input  wire logic [WIDTH-1:0] pins,
    output logic      [WIDTH-1:0] pins_sync
);

    // first stage feeds only the second stage
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            meta_r    <= '0;
            pins_sync <= '0;
        end
        else
        begin
            meta_r    <= pins;
            pins_sync <= meta_r;
        end
    end

endmodule : pin_sync

`default_nettype wire

// ==== host_strap_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module host_strap_model
    import host_if_pkg::*;
(
    // strap choice from the bench
    input  wire mode_t      sel,
    input  wire logic       scramble,
    // levels a serial host puts on its lines once the straps are read
    input  wire logic       host_latch,
    input  wire logic       host_mosi,
    input  wire logic       host_sck,
    // board levels seen by the device
    output logic            latch_pin,
    output logic      [5:0] addr,
    output logic            rd_n,
    output logic            wr_n,
    output logic            cs_n,
    output logic      [7:0] data
);
    logic [5:0] addr_strap;
    logic       latch_strap;
    logic       serial_sel;
    logic       spi_sel;

    // serial hosts reuse the latch pin as rx, nss or sda, so it is no strap there
    assign serial_sel = (sel == MODE_UART) || (sel == MODE_SPI) || (sel == MODE_I2C);
    assign spi_sel    = (sel == MODE_SPI);

    // board wiring is fixed; scramble mimics strap pins reused by later bus traffic
    always_comb
    begin
        latch_strap = serial_sel ? host_latch : 1'b1;
        case (sel)
            MODE_UART:    addr_strap = 6'h00;
            MODE_SPI:     addr_strap = 6'h01;
            MODE_I2C:     addr_strap = 6'h03;
            MODE_SEP_MUX: addr_strap = 6'h07;
            MODE_COM_MUX: addr_strap = 6'h06;
            MODE_SEP_DED: addr_strap = 6'h2a;
            default:
            begin
                addr_strap  = 6'h3c;
                latch_strap = 1'b0;
            end
        endcase
    end

    assign latch_pin = scramble ? ~latch_strap : latch_strap;
    assign addr      = scramble ? ~addr_strap : addr_strap;
    assign rd_n      = ~scramble;
    assign wr_n      = ~scramble;
    assign cs_n      = 1'b1;
    assign data      = scramble ? 8'ha5 : spi_sel ? {1'b0, host_mosi, host_sck, 5'h0d} : 8'h2d;
endmodule : host_strap_model

`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/100ps
`default_nettype none

module tb
    import host_if_pkg::*;
;
    logic       core_clk, rst, scramble, latch_pin, rd_n, wr_n, cs_n;
    logic       uart_tx_data, uart_mux_out, uart_transfer_request, spi_miso, i2c_sda_low;
    logic [5:0] addr;
    logic [7:0] data, data_pin_out, data_pin_oe;
    logic       latch_enable_out, latch_enable_oe, mode_valid, uart_rx;
    logic       host_latch, host_mosi, host_sck, par_oe;
    logic [7:0] par_out;
    mode_t      sel, host_mode, host_mode_com;
    spi_bus_t   spi_bus;
    i2c_bus_t   i2c_bus;
    par_bus_t   par_bus;
    int         error_cnt, total_checks, cycle_cnt;

    host_strap_model board (.sel(sel), .scramble(scramble), .host_latch(host_latch), .host_mosi(host_mosi),
        .host_sck(host_sck), .latch_pin(latch_pin), .addr(addr),
        .rd_n(rd_n), .wr_n(wr_n), .cs_n(cs_n), .data(data));

    host_interface_autodetect dut (.core_clk(core_clk), .rst(rst), .latch_enable_pin(latch_pin),
        .latch_enable_out(latch_enable_out), .latch_enable_oe(latch_enable_oe), .addr_pin(addr),
        .read_strobe_n(rd_n), .write_strobe_n(wr_n), .chip_select_n(cs_n), .data_pin_in(data),
        .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe), .uart_tx_data(uart_tx_data),
        .uart_mux_out(uart_mux_out), .uart_transfer_request(uart_transfer_request),
        .spi_miso(spi_miso), .i2c_sda_low(i2c_sda_low), .par_data_out(par_out), .par_data_oe(par_oe),
        .host_mode(host_mode), .mode_valid(mode_valid), .uart_rx(uart_rx), .spi_bus(spi_bus),
        .i2c_bus(i2c_bus), .par_bus(par_bus));

    // second copy whose dedicated bus uses a common strobe
    host_interface_autodetect #(.DED_COMMON_STROBE(1'b1)) dut_com (.core_clk(core_clk), .rst(rst),
        .latch_enable_pin(latch_pin), .latch_enable_out(), .latch_enable_oe(), .addr_pin(addr),
        .read_strobe_n(rd_n), .write_strobe_n(wr_n), .chip_select_n(cs_n), .data_pin_in(data),
        .data_pin_out(), .data_pin_oe(), .uart_tx_data(1'b0), .uart_mux_out(1'b0),
        .uart_transfer_request(1'b0), .spi_miso(1'b0), .i2c_sda_low(1'b0), .par_data_out(8'h00),
        .par_data_oe(1'b0), .host_mode(host_mode_com), .mode_valid(), .uart_rx(), .spi_bus(),
        .i2c_bus(), .par_bus());

    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // about 330 cycles are needed; the ceiling leaves ample margin
    always @(posedge core_clk)
    begin
        cycle_cnt <= cycle_cnt + 1;
        if (cycle_cnt == 2000)
        begin
            error_cnt = error_cnt + 1;
            end_sim();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        total_checks = total_checks + 1;
        if (seen !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim

    // detection lands on the sixth edge after release, never earlier
    task automatic do_reset(input mode_t m);
        rst = 1'b1;
        sel = m;
        scramble = 1'b0;
        repeat (16) @(negedge core_clk);
        check(mode_valid, 1'b0, "valid in reset");
        check(data_pin_oe, 8'h00, "oe in reset");
        rst = 1'b0;
        repeat (5) @(negedge core_clk);
        check(mode_valid, 1'b0, "valid early");
        @(negedge core_clk);
        check(mode_valid, 1'b1, "valid late");
    endtask : do_reset

    task automatic t_detect_all;
        for (int i = 0; i < 7; i++)
        begin
            do_reset(mode_t'(i));
            check(host_mode, mode_t'(i), "detected mode");
            check(host_mode_com, (i == 6) ? MODE_COM_DED : mode_t'(i), "common strobe mode");
        end
        $display("detect test done");
    endtask : t_detect_all

    task automatic t_hold;
        do_reset(MODE_UART);
        scramble = 1'b1;
        repeat (10) @(negedge core_clk);
        check(host_mode, MODE_UART, "mode held");
        check(mode_valid, 1'b1, "valid held");
        $display("hold test done");
    endtask : t_hold

    // pin to core takes two sync edges and one output edge
    task automatic t_uart;
        do_reset(MODE_UART);
        uart_tx_data = 1'b1;
        uart_mux_out = 1'b0;
        uart_transfer_request = 1'b1;
        host_latch = 1'b0;
        @(negedge core_clk);
        check(data_pin_oe, 8'he0, "uart oe");
        check(data_pin_out[7:5], 3'h5, "uart pins");
        check(uart_rx, 1'b1, "uart rx");
        repeat (2) @(negedge core_clk);
        check(uart_rx, 1'b0, "uart rx low");
        host_latch = 1'b1;
        $display("uart test done");
    endtask : t_uart

    task automatic spi_level(input logic nss_n, input logic mosi, input logic sck);
        host_latch = nss_n;
        host_mosi = mosi;
        host_sck = sck;
        repeat (3) @(negedge core_clk);
        check(spi_bus.nss, nss_n, "spi nss level");
        check(spi_bus.mosi, mosi, "spi mosi level");
        check(spi_bus.sck, sck, "spi sck level");
        check(data_pin_oe, nss_n ? 8'h00 : 8'h80, "miso enable");
        check(data_pin_out[7], 1'b1, "miso level");
    endtask : spi_level

    task automatic t_spi;
        logic [7:0] first_byte;
        do_reset(MODE_SPI);
        spi_miso = 1'b1;
        @(negedge core_clk);
        check(spi_bus.nss, 1'b1, "spi nss");
        check(spi_bus.sck, 1'b1, "spi sck");
        check(spi_bus.mosi, 1'b0, "spi mosi");
        check(data_pin_oe, 8'h00, "miso off while deselected");
        // read request to an arbitrary register, sent msb first
        first_byte = {1'b1, 6'h15, 1'b0};
        for (int b = 7; b >= 0; b--)
        begin
            spi_level(1'b0, first_byte[b], 1'b0);
            spi_level(1'b0, first_byte[b], 1'b1);
        end
        spi_level(1'b1, 1'b0, 1'b1);
        $display("spi test done");
    endtask : t_spi

    task automatic t_i2c;
        do_reset(MODE_I2C);
        i2c_sda_low = 1'b1;
        host_latch = 1'b0;
        @(negedge core_clk);
        // pins 2d give d6..d0 reversed into the address field
        check(i2c_bus.slave_addr, 7'h5a, "i2c address");
        check(i2c_bus.address_mode_pin, 1'b1, "i2c address mode");
        check(latch_enable_oe, 1'b1, "sda pull low");
        check(latch_enable_out, 1'b0, "sda low level");
        check(i2c_bus.scl, 1'b0, "i2c scl");
        i2c_sda_low = 1'b0;
        repeat (2) @(negedge core_clk);
        check(i2c_bus.sda_in, 1'b0, "i2c sda in");
        check(latch_enable_oe, 1'b0, "sda released");
        host_latch = 1'b1;
        $display("i2c test done");
    endtask : t_i2c

    task automatic t_par;
        do_reset(MODE_SEP_MUX);
        par_out = 8'h3c;
        par_oe = 1'b1;
        @(negedge core_clk);
        check(par_bus, {1'b1, 6'h07, 1'b1, 1'b1, 1'b1, 8'h2d}, "mux bus pins");
        check(data_pin_oe, 8'hff, "mux bus drive");
        check(data_pin_out, 8'h3c, "mux bus data");
        par_oe = 1'b0;
        $display("par test done");
    endtask : t_par

    initial
    begin
        {rst, uart_tx_data, uart_mux_out, uart_transfer_request, spi_miso, i2c_sda_low} = 6'h20;
        {host_latch, host_mosi, host_sck, par_oe} = 4'ha;
        par_out = 8'h00;
        sel = MODE_NONE;
        scramble = 1'b0;
        {error_cnt, total_checks, cycle_cnt} = '0;
        t_detect_all();
        t_hold();
        t_uart();
        t_spi();
        t_i2c();
        t_par();
        end_sim();
    end
endmodule : tb

`default_nettype wire
